// ### rtl/rfi_pkg.sv
// package: register layouts, reset values and codes of the fault-inject and status record
package rfi_pkg;
  // record select window and register indices
  localparam logic [1:0] RFI_SEL_RECORD0 = 2'h0;
  localparam logic [1:0] RFI_IDX_CTRL = 2'h0;
  localparam logic [1:0] RFI_IDX_FEAT = 2'h1;
  localparam logic [1:0] RFI_IDX_STATUS = 2'h2;
  localparam logic [1:0] RFI_IDX_COUNT = 2'h3;
  // reset values
  localparam logic [31:0] RFI_CTRL_RESET = 32'h00000000;
  localparam logic [31:0] RFI_FEAT_VALUE = 32'hC0000062;
  localparam logic [31:0] RFI_STATUS_RESET = 32'h00000000;
  localparam logic [31:0] RFI_COUNT_RESET = 32'h00000000;
  // control field positions
  localparam int RFI_CTL_CDN_EN = 31;
  localparam int RFI_CTL_RESTART = 30;
  localparam int RFI_CTL_CE_HI = 7;
  localparam int RFI_CTL_CE_LO = 6;
  localparam int RFI_CTL_DEFER = 5;
  localparam int RFI_CTL_LATENT = 4;
  localparam int RFI_CTL_SIGNALED = 3;
  localparam int RFI_CTL_UNRECOV = 2;
  localparam int RFI_CTL_UC = 1;
  localparam int RFI_CTL_OVF = 0;
  // writable control bits; latent, signaled and unrecoverable stay zero
  localparam logic [31:0] RFI_CTRL_WMASK = 32'hC00000E3;
  // status field positions
  localparam int RFI_ST_ADDR_V = 31;
  localparam int RFI_ST_VALID = 30;
  localparam int RFI_ST_UE = 29;
  localparam int RFI_ST_ABORT = 28;
  localparam int RFI_ST_OVF = 27;
  localparam int RFI_ST_MISC_V = 26;
  localparam int RFI_ST_CE_HI = 25;
  localparam int RFI_ST_CE_LO = 24;
  localparam int RFI_ST_DEFER = 23;
  localparam int RFI_ST_POISON = 22;
  localparam int RFI_ST_UET_HI = 21;
  localparam int RFI_ST_UET_LO = 20;
  localparam int RFI_ST_PRIMARY_ERROR_CODE_HI = 4;
  localparam int RFI_ST_PRIMARY_ERROR_CODE_LO = 0;
  localparam logic [1:0] RFI_CE_NONE = 2'h0;
  localparam logic [1:0] RFI_CE_SEEN = 2'h2;
  localparam logic [1:0] RFI_UET_UNCONTAINABLE = 2'h0;
  // primary error codes
  localparam logic [4:0] RFI_PRIMARY_ERROR_CODE_NONE = 5'h00;
  localparam logic [4:0] RFI_PRIMARY_ERROR_CODE_IMPDEF = 5'h01;
  localparam logic [4:0] RFI_PRIMARY_ERROR_CODE_BUF_ECC = 5'h02;
  localparam logic [4:0] RFI_PRIMARY_ERROR_CODE_INJ_TAG = 5'h05;
  localparam logic [4:0] RFI_PRIMARY_ERROR_CODE_DATA_ECC = 5'h06;
  localparam logic [4:0] RFI_PRIMARY_ERROR_CODE_TAG_ECC = 5'h07;
  localparam logic [4:0] RFI_PRIMARY_ERROR_CODE_TLB_PAR = 5'h08;
  localparam logic [4:0] RFI_PRIMARY_ERROR_CODE_COPYBACK = 5'h12;
  localparam logic [4:0] RFI_PRIMARY_ERROR_CODE_DEFER_UNSUP = 5'h15;
  // error class of an incoming or injected error
  typedef enum logic [2:0] {
    RFI_CLS_CORRECTED = 3'b001,
    RFI_CLS_DEFERRED = 3'b010,
    RFI_CLS_UNCORRECTED = 3'b100
  } rfi_class_t;
  // counter states, one-hot
  typedef enum logic [2:0] {
    RFI_CNT_IDLE = 3'b001,
    RFI_CNT_RUN = 3'b010,
    RFI_CNT_DONE = 3'b100
  } rfi_cnt_state_t;
endpackage

// ### rtl/rfi_trig_if.sv
// interface: link between the register record and the error generation counter
`timescale 1ns/1ps
interface rfi_trig_if;
  logic enable;
  logic restart;
  logic load;
  logic [31:0] reload;
  logic fire;
  logic [31:0] count;
  modport rec (output enable, output restart, output load, output reload, input fire, input count);
  modport cnt (input enable, input restart, input load, input reload, output fire, output count);
endinterface

// ### rtl/rfi_counter.sv
// module: error generation countdown counter
`timescale 1ns/1ps
module rfi_counter
  import rfi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic err_recovery_rst,
  rfi_trig_if.cnt trig
);
  import rfi_pkg::*;

  rfi_cnt_state_t state_reg, state_next;
  logic [31:0] count_reg, count_next;
  logic fire_reg, fire_next;

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    fire_next = 1'b0;
    case (state_reg)
      RFI_CNT_IDLE: begin
        // load comes with the enabling write, one cycle before enable shows
        if (trig.load) begin
          count_next = trig.reload;
          state_next = RFI_CNT_RUN;
        end
      end
      RFI_CNT_RUN: begin
        if (!trig.enable) begin
          state_next = RFI_CNT_IDLE;
        end else if (count_reg == 32'h00000000 || count_reg == 32'h00000001) begin
          fire_next = 1'b1;
          count_next = 32'h00000000;
          if (trig.restart) begin
            count_next = trig.reload;
          end else begin
            state_next = RFI_CNT_DONE;
          end
        end else begin
          count_next = count_reg - 32'h00000001;
        end
      end
      RFI_CNT_DONE: begin
        // stopped at zero until enable is cleared
        if (!trig.enable || trig.load) begin
          state_next = RFI_CNT_IDLE;
        end
      end
      default: begin
        state_next = RFI_CNT_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst || err_recovery_rst) begin
      state_reg <= RFI_CNT_IDLE;
      count_reg <= RFI_COUNT_RESET;
      fire_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      count_reg <= count_next;
      fire_reg <= fire_next;
    end
  end

  assign trig.fire = fire_reg & clk_en;
  assign trig.count = count_reg;
endmodule // rfi_counter

// ### rtl/rfi_record.sv
// module: error record with pseudo-fault injection control, features and primary status
`timescale 1ns/1ps
module rfi_record
  import rfi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic err_recovery_rst,
  input wire logic [1:0] record_select,
  input wire logic [1:0] reg_index,
  input wire logic reg_wr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  input wire logic err_valid,
  input wire rfi_pkg::rfi_class_t err_class,
  input wire logic [4:0] err_code,
  input wire logic [63:0] err_addr,
  input wire logic err_addr_ok,
  input wire logic err_abort,
  input wire logic err_misc,
  input wire logic inject_data_side,
  input wire logic inject_addr_ok,
  input wire logic [63:0] inject_addr,
  input wire logic recovery_irq_en,
  output logic recovery_irq,
  output logic inject_fire,
  output logic [63:0] fault_address,
  output logic [31:0] misc_syndrome
);
  import rfi_pkg::*;

  // ****************************************
  // register access
  // ****************************************
  logic [31:0] ctrl_reg, ctrl_next;
  logic [31:0] cdn_reg, cdn_next;
  logic [31:0] status_reg, status_next;
  logic [63:0] addr_reg, addr_next;
  logic [31:0] misc_reg, misc_next;
  logic sel_ok;
  logic wr_ctrl, wr_status, wr_cdn;
  rfi_trig_if trig();

  assign sel_ok = (record_select == RFI_SEL_RECORD0);
  assign wr_ctrl = clk_en && reg_wr && sel_ok && reg_index == RFI_IDX_CTRL;
  assign wr_status = clk_en && reg_wr && sel_ok && reg_index == RFI_IDX_STATUS;
  assign wr_cdn = clk_en && reg_wr && sel_ok && reg_index == RFI_IDX_COUNT;

  // ****************************************
  // injection decode
  // ****************************************
  logic inj_any, inj_ce, inj_de, inj_uc;
  assign inj_ce = ctrl_reg[RFI_CTL_CE_HI:RFI_CTL_CE_LO] != 2'h0;
  assign inj_de = ctrl_reg[RFI_CTL_DEFER];
  assign inj_uc = ctrl_reg[RFI_CTL_UC];
  assign inj_any = trig.fire && (inj_ce || inj_de || inj_uc);

  // priority of an error class: uncorrected above deferred above corrected
  function automatic logic [1:0] class_rank(input logic ue, input logic de, input logic ce);
    class_rank = ue ? 2'h3 : (de ? 2'h2 : (ce ? 2'h1 : 2'h0));
  endfunction

  always_comb begin
    ctrl_next = ctrl_reg;
    cdn_next = cdn_reg;
    status_next = status_reg;
    addr_next = addr_reg;
    misc_next = misc_reg;
    trig.load = 1'b0;
    if (wr_ctrl) begin
      ctrl_next = reg_wdata & RFI_CTRL_WMASK;
      // a rising enable copies the countdown value in
      trig.load = reg_wdata[RFI_CTL_CDN_EN] && !ctrl_reg[RFI_CTL_CDN_EN];
    end
    if (wr_cdn) begin
      cdn_next = reg_wdata;
    end
    // software clears status bits by writing one
    if (wr_status) begin
      status_next = status_reg & ~reg_wdata;
      if (reg_wdata[RFI_ST_CE_HI]) begin
        status_next[RFI_ST_CE_HI:RFI_ST_CE_LO] = RFI_CE_NONE;
      end
    end
    // new events win over a clear in the same cycle
    if (clk_en && err_valid) begin
      record_event(err_class == RFI_CLS_UNCORRECTED, err_class == RFI_CLS_DEFERRED,
        err_class == RFI_CLS_CORRECTED, err_code, err_addr_ok, err_addr, err_abort, err_misc, 1'b0);
    end else if (clk_en && inj_any) begin
      record_event(inj_uc, inj_de && !inj_uc, inj_ce && !inj_uc && !inj_de,
        inject_data_side ? RFI_PRIMARY_ERROR_CODE_DATA_ECC : RFI_PRIMARY_ERROR_CODE_INJ_TAG, inject_addr_ok, inject_addr,
        1'b0, 1'b1, 1'b1);
    end
    status_next[RFI_ST_POISON] = 1'b0;
    status_next[RFI_ST_UET_HI:RFI_ST_UET_LO] = RFI_UET_UNCONTAINABLE;
    status_next[19:5] = 15'h0000;
  end

  // ****************************************
  // recording of one error
  // ****************************************
  task automatic record_event(input logic ue, input logic de, input logic ce, input logic [4:0] code,
    input logic aok, input logic [63:0] addr, input logic abort, input logic misc, input logic inj);
    logic [1:0] old_rank;
    logic [1:0] new_rank;
    old_rank = class_rank(status_next[RFI_ST_UE], status_next[RFI_ST_DEFER],
      status_next[RFI_ST_CE_HI]);
    new_rank = class_rank(ue, de, ce);
    if (status_next[RFI_ST_VALID] && new_rank <= old_rank) begin
      status_next[RFI_ST_OVF] = 1'b1;
    end
    if (inj) begin
      status_next[RFI_ST_OVF] = ctrl_reg[RFI_CTL_OVF];
    end
    status_next[RFI_ST_VALID] = 1'b1;
    if (ue) begin
      status_next[RFI_ST_UE] = 1'b1;
    end
    if (de) begin
      status_next[RFI_ST_DEFER] = 1'b1;
    end
    if (ce) begin
      status_next[RFI_ST_CE_HI:RFI_ST_CE_LO] = RFI_CE_SEEN;
    end
    if (abort) begin
      status_next[RFI_ST_ABORT] = 1'b1;
    end
    // only the first error, a higher-priority error or an injected one owns code, address and syndrome
    if (!status_reg[RFI_ST_VALID] || new_rank > old_rank || inj) begin
      status_next[RFI_ST_PRIMARY_ERROR_CODE_HI:RFI_ST_PRIMARY_ERROR_CODE_LO] = code;
      if (aok) begin
        addr_next = addr;
        status_next[RFI_ST_ADDR_V] = 1'b1;
      end else if (!inj) begin
        status_next[RFI_ST_ADDR_V] = 1'b0;
      end
      if (misc) begin
        misc_next = {27'h0000000, code};
        status_next[RFI_ST_MISC_V] = 1'b1;
      end
    end
  endtask

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ctrl_reg <= RFI_CTRL_RESET;
      cdn_reg <= RFI_COUNT_RESET;
      status_reg <= RFI_STATUS_RESET;
      addr_reg <= 64'h0000000000000000;
      misc_reg <= 32'h00000000;
    end else if (err_recovery_rst) begin
      // control keeps all fields except the countdown enable across error recovery, counter stops
      ctrl_reg <= ctrl_reg & ~(32'h1 << RFI_CTL_CDN_EN);
      status_reg <= RFI_STATUS_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
      cdn_reg <= cdn_next;
      status_reg <= status_next;
      addr_reg <= addr_next;
      misc_reg <= misc_next;
    end
  end

  // ****************************************
  // counter and outputs
  // ****************************************
  assign trig.enable = ctrl_reg[RFI_CTL_CDN_EN];
  assign trig.restart = ctrl_reg[RFI_CTL_RESTART];
  assign trig.reload = cdn_reg;

  rfi_counter u_counter (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .err_recovery_rst(err_recovery_rst),
    .trig(trig)
  );

  always_comb begin
    reg_rdata = 32'h00000000;
    if (sel_ok) begin
      case (reg_index)
        RFI_IDX_CTRL: reg_rdata = ctrl_reg;
        RFI_IDX_FEAT: reg_rdata = RFI_FEAT_VALUE;
        RFI_IDX_STATUS: reg_rdata = status_reg;
        RFI_IDX_COUNT: reg_rdata = cdn_reg;
        default: reg_rdata = 32'h00000000;
      endcase
    end
  end

  // level until software or an error recovery reset clears the uncorrected flag
  assign recovery_irq = recovery_irq_en && status_reg[RFI_ST_UE];
  assign inject_fire = inj_any;
  assign fault_address = addr_reg;
  assign misc_syndrome = misc_reg;
endmodule // rfi_record

// ### bench/rfi_record_checker.sv
// checker: port-level properties of the error record
`timescale 1ns/1ps
module rfi_record_checker
  import rfi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic err_valid,
  input wire logic err_recovery_rst,
  input wire logic [1:0] record_select,
  input wire logic [1:0] reg_index,
  input wire logic [31:0] reg_rdata,
  input wire logic inject_data_side,
  input wire logic recovery_irq_en,
  input wire logic recovery_irq,
  input wire logic inject_fire
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic st_rd;
  logic ct_rd;
  logic inj_rec;
  logic ft_rd;
  logic any_err;
  // a real event in the same cycle wins, so only a lone fire counts as an injected record
  assign st_rd = record_select == RFI_SEL_RECORD0 && reg_index == RFI_IDX_STATUS;
  assign ct_rd = record_select == RFI_SEL_RECORD0 && reg_index == RFI_IDX_CTRL;
  assign inj_rec = inject_fire && clk_en && !err_valid && !err_recovery_rst;
  assign ft_rd = record_select == RFI_SEL_RECORD0 && reg_index == RFI_IDX_FEAT;
  assign any_err = reg_rdata[29] || reg_rdata[23] || reg_rdata[25];
  chk_feat_const: assert property (ft_rd |-> reg_rdata == 32'hC0000062)
    else $error("feature register value wrong");
  chk_ctrl_rsvd: assert property (ct_rd |-> reg_rdata[29:8] == 22'h0 && reg_rdata[4:2] == 3'h0)
    else $error("control reserved bits not zero");
  chk_poison_kind: assert property (st_rd |-> reg_rdata[22:20] == 3'h0)
    else $error("poison or uncorrected kind not zero");
  chk_ce_field: assert property (st_rd |-> reg_rdata[25:24] != 2'h1 && reg_rdata[25:24] != 2'h3)
    else $error("corrected field illegal");
  chk_valid_flag: assert property (st_rd && any_err |-> reg_rdata[30])
    else $error("error recorded without valid");
  chk_irq_level: assert property (st_rd |-> recovery_irq == (recovery_irq_en && reg_rdata[29]))
    else $error("recovery irq level wrong");
  chk_inj_flags: assert property (
    inj_rec ##1 st_rd |-> reg_rdata[30] && reg_rdata[26] && !reg_rdata[22])
    else $error("injected record flags wrong");
  chk_inj_code: assert property (
    inj_rec ##1 st_rd |-> reg_rdata[4:0] == ($past(inject_data_side) ? 5'h06 : 5'h05))
    else $error("injected code wrong");
  chk_ctrl_reset: assert property (
    disable iff (1'h0) !nrst ##1 ct_rd |-> reg_rdata == 32'h00000000)
    else $error("control not zero after reset");
endmodule // rfi_record_checker

bind rfi_record rfi_record_checker u_chk (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .err_valid(err_valid),
  .err_recovery_rst(err_recovery_rst), .record_select(record_select), .reg_index(reg_index), .reg_rdata(reg_rdata),
  .inject_data_side(inject_data_side), .recovery_irq_en(recovery_irq_en), .recovery_irq(recovery_irq),
  .inject_fire(inject_fire));

// ### bench/rfi_record_tb_top.sv
// testbench: registers, error recording and fault injection of the error record
`timescale 1ns/1ps
module rfi_record_tb_top;
  import rfi_pkg::*;
  typedef struct {logic [1:0] sel; logic [1:0] idx; logic [31:0] wd; logic [31:0] exp;} rfi_row_t;
  logic sys_clk = 1'h0;
  logic nrst = 1'h0;
  logic clk_en = 1'h1;
  logic err_recovery_rst = 1'h0;
  logic [1:0] record_select = 2'h0;
  logic [1:0] reg_index = 2'h0;
  logic reg_wr = 1'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic err_valid = 1'h0;
  rfi_class_t err_class = RFI_CLS_CORRECTED;
  logic [4:0] err_code = 5'h00;
  logic [63:0] err_addr = 64'h0000123456789AC0;
  logic err_addr_ok = 1'h1;
  logic err_abort = 1'h0;
  logic err_misc = 1'h0;
  logic inject_data_side = 1'h0;
  logic inject_addr_ok = 1'h0;
  logic [63:0] inject_addr = 64'h000000000BAD0F00;
  logic recovery_irq_en = 1'h1;
  logic [31:0] reg_rdata;
  logic recovery_irq;
  logic inject_fire;
  logic [63:0] fault_address;
  logic [31:0] misc_syndrome;
  int bad_count = 0;
  int tests_run = 0;
  int fires;
  int n;
  logic [4:0] codes [7] = '{5'h01, 5'h02, 5'h06, 5'h07, 5'h08, 5'h12, 5'h15};
  rfi_row_t rows [6] = '{'{2'h0, 2'h0, 32'h3FFFFFFF, 32'h000000E3}, '{2'h0, 2'h0, 32'h00000000, 32'h00000000},
    '{2'h0, 2'h1, 32'h00000000, 32'hC0000062}, '{2'h1, 2'h0, 32'h000000FF, 32'h00000000},
    '{2'h0, 2'h3, 32'h12345678, 32'h12345678}, '{2'h0, 2'h3, 32'h00000003, 32'h00000003}};

  rfi_record DUT (.sys_clk, .nrst, .clk_en, .err_recovery_rst, .record_select, .reg_index, .reg_wr, .reg_wdata,
    .reg_rdata, .err_valid, .err_class, .err_code, .err_addr, .err_addr_ok, .err_abort, .err_misc, .inject_data_side,
    .inject_addr_ok, .inject_addr, .recovery_irq_en, .recovery_irq, .inject_fire, .fault_address, .misc_syndrome);

  always #10 sys_clk = ~sys_clk;

  // ****************************************
  // bus and check tasks
  // ****************************************
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task wr(input logic [1:0] sel, input logic [1:0] idx, input logic [31:0] d);
    @(posedge sys_clk);
    record_select <= sel;
    reg_index <= idx;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
    record_select <= 2'h0;
  endtask
  // read data is combinational, sampled 1 ns after the edge that set the index
  task rd(input string what, input logic [1:0] idx, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_index <= idx;
    #1;
    check(what, reg_rdata, exp);
  endtask
  task ev(input rfi_class_t c, input logic [4:0] code, input logic ab, input logic ms);
    @(posedge sys_clk);
    err_valid <= 1'h1;
    err_class <= c;
    err_code <= code;
    err_abort <= ab;
    err_misc <= ms;
    @(posedge sys_clk);
    err_valid <= 1'h0;
  endtask
  task count_fires(input int cyc);
    fires = 0;
    repeat (cyc) begin
      @(posedge sys_clk);
      #1;
      if (inject_fire === 1'h1) fires++;
    end
  endtask

  initial begin
    repeat (4000) @(posedge sys_clk);
    bad_count++;
    stop_test;
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    nrst <= 1'h1;
    rd("ctrl reset", RFI_IDX_CTRL, 32'h0);
    rd("status reset", RFI_IDX_STATUS, 32'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].sel, rows[i].idx, rows[i].wd);
      rd("table row", rows[i].idx, rows[i].exp);
    end
    $display("test register table done");
    foreach (codes[i]) begin
      ev(RFI_CLS_CORRECTED, codes[i], 1'h0, 1'h0);
      rd("code", RFI_IDX_STATUS, {8'hC2, 19'h0, codes[i]});
      wr(2'h0, RFI_IDX_STATUS, 32'hFFFFFFFF);
    end
    check("address", fault_address[31:0], err_addr[31:0]);
    ev(RFI_CLS_CORRECTED, RFI_PRIMARY_ERROR_CODE_DATA_ECC, 1'h0, 1'h0);
    ev(RFI_CLS_DEFERRED, RFI_PRIMARY_ERROR_CODE_COPYBACK, 1'h1, 1'h1);
    rd("deferred", RFI_IDX_STATUS, 32'hD6800012);
    check("misc", misc_syndrome, 32'h00000012);
    ev(RFI_CLS_CORRECTED, RFI_PRIMARY_ERROR_CODE_TAG_ECC, 1'h0, 1'h0);
    rd("overflow", RFI_IDX_STATUS, 32'hDE800012);
    wr(2'h0, RFI_IDX_STATUS, 32'hFFFFFFFF);
    ev(RFI_CLS_UNCORRECTED, RFI_PRIMARY_ERROR_CODE_DEFER_UNSUP, 1'h0, 1'h0);
    rd("uncorrected", RFI_IDX_STATUS, 32'hE0000015);
    check("irq on", {31'h0, recovery_irq}, 32'h1);
    @(posedge sys_clk);
    recovery_irq_en <= 1'h0;
    rd("uncorrected masked", RFI_IDX_STATUS, 32'hE0000015);
    check("irq masked", {31'h0, recovery_irq}, 32'h0);
    @(posedge sys_clk);
    recovery_irq_en <= 1'h1;
    wr(2'h0, RFI_IDX_STATUS, 32'hFFFFFFFF);
    rd("cleared", RFI_IDX_STATUS, 32'h0);
    check("irq off", {31'h0, recovery_irq}, 32'h0);
    $display("test real errors done");
    wr(2'h0, RFI_IDX_CTRL, 32'h80000023);
    n = 0;
    while (inject_fire !== 1'h1 && n < 50) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check("fire seen", {31'h0, n < 50}, 32'h1);
    rd("inject uc", RFI_IDX_STATUS, 32'h6C000005);
    count_fires(20);
    check("no restart", 32'(fires), 32'h0);
    wr(2'h0, RFI_IDX_CTRL, 32'h0);
    wr(2'h0, RFI_IDX_STATUS, 32'hFFFFFFFF);
    inject_data_side <= 1'h1;
    inject_addr_ok <= 1'h1;
    wr(2'h0, RFI_IDX_CTRL, 32'hC0000040);
    count_fires(20);
    check("restart", {31'h0, fires >= 2}, 32'h1);
    rd("inject ce", RFI_IDX_STATUS, 32'hC6000006);
    check("inject addr", fault_address[31:0], inject_addr[31:0]);
    $display("test injection done");
    // long count so no fire can meet the recovery reset edge
    wr(2'h0, RFI_IDX_CTRL, 32'h0);
    wr(2'h0, RFI_IDX_COUNT, 32'h000003E8);
    wr(2'h0, RFI_IDX_CTRL, 32'hC0000040);
    @(posedge sys_clk);
    err_recovery_rst <= 1'h1;
    @(posedge sys_clk);
    err_recovery_rst <= 1'h0;
    rd("recovery ctrl", RFI_IDX_CTRL, 32'h40000040);
    rd("recovery status", RFI_IDX_STATUS, 32'h0);
    $display("test recovery reset done");
    stop_test;
  end
endmodule // rfi_record_tb_top
